// ### verilog/gwt_timers.sv
// General purpose timer and wake-up timer.
// Assumes carrierTick (crystal-derived) and rcTick (RC oscillator) are
// one-cycle enables in the clk domain, and commands are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module gwt_timers #(
  parameter int GEN_W  = gwt_pkg::GEN_CNT_W,
  parameter int WAKE_W = gwt_pkg::WAKE_CNT_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire gwt_pkg::gwt_mode_t  opMode,
  input  wire logic                carrierTick,
  input  wire logic                rcTick,
  input  wire logic                genTrigSel,
  input  wire logic [GEN_W-1:0]    genTimeout,
  input  wire logic [WAKE_W-1:0]   wakeTimeout,
  input  wire logic                rxSofSeen,
  input  wire logic                rxEofSeen,
  input  wire logic                cmdStartGen,
  input  wire logic                cmdStartWake,
  input  wire logic                cmdStopAll,
  input  wire logic                peerFieldDetected,
  input  wire logic                wakeFlagClear,
  output logic                     genRunning,
  output logic                     genExpired,
  output logic                     wakeRunning,
  output logic                     rcOscEnable,
  output logic                     tempEnable,
  output logic                     wake_timer_expired_flag,
  output logic                     irqReq
);

  // Narrower counters cannot hold a useful timeout; wider ones slow the compare
  if (GEN_W < 2 || GEN_W > 32 || WAKE_W < 2 || WAKE_W > 32) begin : g_bad_width
    $error("Timer widths must lie between 2 and 32");
  end

  // ****************************************
  // General purpose timer
  // ****************************************
  logic             genRun_ff;
  logic [GEN_W-1:0] genCnt_ff;
  logic             genExp_ff;
  logic             genTrig;
  logic             genTick;
  logic             xtalOn;

  // Crystal is stopped in power-down, so its ticks are ignored there
  assign xtalOn  = (opMode != gwt_pkg::GWT_MODE_PWRDN);
  assign genTick = carrierTick && xtalOn;
  assign genTrig = (genTrigSel == gwt_pkg::GEN_TRIG_RX_START) ? rxSofSeen
                                                              : rxEofSeen;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      genRun_ff <= 1'b0;
      genCnt_ff <= GEN_W'(gwt_pkg::CNT_RST);
      genExp_ff <= 1'b0;
    end else begin
      genExp_ff <= 1'b0;
      if (cmdStopAll) begin
        genRun_ff <= 1'b0;
        genCnt_ff <= '0;
      end else if ((cmdStartGen || genTrig) && xtalOn) begin
        genRun_ff <= 1'b1;
        genCnt_ff <= '0;
      end else if (genRun_ff && genTick) begin
        if (genCnt_ff + GEN_W'(1) >= genTimeout) begin
          genRun_ff <= 1'b0;
          genCnt_ff <= '0;
          genExp_ff <= 1'b1;
        end else begin
          genCnt_ff <= genCnt_ff + GEN_W'(1);
        end
      end
    end
  end

  assign genRunning = genRun_ff;
  assign genExpired = genExp_ff;

  // ****************************************
  // Wake-up timer
  // ****************************************
  gwt_pkg::gwt_state_t wakeState_ff;
  logic [WAKE_W-1:0]   wakeCnt_ff;
  logic                wakeHit;
  logic                wakeStartOk;
  logic                tempEn_ff;
  logic                flag_ff;

  assign wakeStartOk = cmdStartWake && (opMode != gwt_pkg::GWT_MODE_WAKEUP);
  assign wakeHit     = (wakeState_ff == gwt_pkg::GWT_RUN) && rcTick
                       && (wakeCnt_ff + WAKE_W'(1) >= wakeTimeout);

  // A start while running is ignored: only the general purpose timer restarts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeState_ff <= gwt_pkg::GWT_IDLE;
      wakeCnt_ff   <= WAKE_W'(gwt_pkg::CNT_RST);
    end else begin
      case (wakeState_ff)
        gwt_pkg::GWT_IDLE: begin
          wakeCnt_ff <= '0;
          if (!cmdStopAll && (wakeStartOk ||
              (opMode == gwt_pkg::GWT_MODE_LPBR && peerFieldDetected && !tempEn_ff))) begin
            wakeState_ff <= gwt_pkg::GWT_RUN;
          end
        end
        gwt_pkg::GWT_RUN: begin
          if (cmdStopAll || wakeHit) begin
            wakeState_ff <= gwt_pkg::GWT_IDLE;
            wakeCnt_ff   <= '0;
          end else if (rcTick) begin
            wakeCnt_ff <= wakeCnt_ff + WAKE_W'(1);
          end
        end
        default: begin
          wakeState_ff <= gwt_pkg::GWT_IDLE;
        end
      endcase
    end
  end

  // Temporary enable in bit-rate detection lasts until the wake-up timeout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tempEn_ff <= 1'b0;
    end else if (opMode != gwt_pkg::GWT_MODE_LPBR || cmdStopAll || wakeHit) begin
      tempEn_ff <= 1'b0;
    end else if (peerFieldDetected && wakeState_ff == gwt_pkg::GWT_IDLE) begin
      tempEn_ff <= 1'b1;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (wakeHit) begin
      flag_ff <= 1'b1;
    end else if (wakeFlagClear) begin
      flag_ff <= 1'b0;
    end
  end

  assign wakeRunning             = (wakeState_ff == gwt_pkg::GWT_RUN);
  assign rcOscEnable             = (wakeState_ff == gwt_pkg::GWT_RUN);
  assign tempEnable              = tempEn_ff;
  assign wake_timer_expired_flag = flag_ff;
  assign irqReq                  = flag_ff;

  // ****************************************
  // Assertions
  // ****************************************
  property p_gen_trig_start;
    @(posedge clk) disable iff (!rst_n)
      (genTrig && xtalOn && !cmdStopAll) |=> (genRunning && genCnt_ff == '0);
  endproperty
  a_gen_trig_start: assert property (p_gen_trig_start) else $error("Timer not started by trigger");

  property p_gen_restart;
    @(posedge clk) disable iff (!rst_n)
      (cmdStartGen && genRunning && xtalOn && !cmdStopAll) |=> (genCnt_ff == '0 && genRunning);
  endproperty
  a_gen_restart: assert property (p_gen_restart) else $error("Timer not restarted");

  property p_wake_refuse;
    @(posedge clk) disable iff (!rst_n)
      (cmdStartWake && opMode == gwt_pkg::GWT_MODE_WAKEUP && !wakeRunning) |=> !wakeRunning;
  endproperty
  a_wake_refuse: assert property (p_wake_refuse) else $error("Wake start taken in wake-up mode");

  property p_wake_start;
    @(posedge clk) disable iff (!rst_n)
      (wakeStartOk && !wakeRunning && !cmdStopAll) |=> rcOscEnable;
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("RC oscillator not enabled");

  property p_wake_flag;
    @(posedge clk) disable iff (!rst_n)
      wakeHit |=> (wake_timer_expired_flag && irqReq && !wakeRunning);
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("Wake expiry not flagged");

  // Stop-all still clears the count in power-down
  property p_pd_gen;
    @(posedge clk) disable iff (!rst_n)
      (opMode == gwt_pkg::GWT_MODE_PWRDN && genRunning && !cmdStopAll) |=> $stable(genCnt_ff);
  endproperty
  a_pd_gen: assert property (p_pd_gen) else $error("Timer counted in power-down");

  property p_lpbr_end;
    @(posedge clk) disable iff (!rst_n)
      (tempEnable && wakeHit) |=> !tempEnable;
  endproperty
  a_lpbr_end: assert property (p_lpbr_end) else $error("Temp enable outlived wake timer");

  property p_stop_all;
    @(posedge clk) disable iff (!rst_n)
      cmdStopAll |=> (!genRunning && !wakeRunning);
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("Stop-all left a timer running");

  property p_one_shot;
    @(posedge clk) disable iff (!rst_n)
      (genExpired && !$past(cmdStartGen) && !$past(genTrig)) |-> !genRunning;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("Timer kept running after timeout");

  c_gen_expire:  cover property (@(posedge clk) disable iff (!rst_n) genExpired);
  c_wake_expire: cover property (@(posedge clk) disable iff (!rst_n) wakeHit);
  c_gen_restart: cover property (@(posedge clk) disable iff (!rst_n) cmdStartGen && genRunning);
  c_lpbr:        cover property (@(posedge clk) disable iff (!rst_n) tempEnable && wakeHit);

endmodule // gwt_timers

`default_nettype wire

// ### verilog/gwt_pkg.sv
// Package for the general purpose and wake-up timer block.
// Assumes a single 100 MHz clock; carrier and RC ticks arrive as enables.
`default_nettype none
package gwt_pkg;

  // ****************************************
  // Trigger selection for the general purpose timer
  // ****************************************
  localparam logic GEN_TRIG_RX_START = 1'b0;
  localparam logic GEN_TRIG_RX_END   = 1'b1;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          GEN_CNT_W     = 16;
  localparam int          WAKE_CNT_W    = 16;
  localparam logic [15:0] CNT_RST       = 16'h0000;

  // ****************************************
  // Operating modes seen by the timers
  // ****************************************
  typedef enum logic [1:0] {
    GWT_MODE_READY,
    GWT_MODE_PWRDN,
    GWT_MODE_WAKEUP,
    GWT_MODE_LPBR
  } gwt_mode_t;

  typedef enum {
    GWT_IDLE,
    GWT_RUN
  } gwt_state_t;

endpackage

`default_nettype wire

// ### dv/gwt_host_model.sv
// Host model: turns bench requests into one-cycle direct command pulses.
// Assumes requests change just after a rising clk edge and last one cycle.
`timescale 1ns/1ns
`default_nettype none

module gwt_host_model (
  input  wire logic               reqGen,
  input  wire logic               reqWake,
  input  wire logic               reqStop,
  input  wire logic               rogueWake,
  input  wire gwt_pkg::gwt_mode_t opMode,
  output logic                    cmdStartGen,
  output logic                    cmdStartWake,
  output logic                    cmdStopAll
);
  assign cmdStartGen  = reqGen;
  // A real host never sends this one while wake-up mode is active;
  // rogueWake breaks that on purpose to probe the device's refusal
  assign cmdStartWake = (reqWake && (opMode != gwt_pkg::GWT_MODE_WAKEUP)) || rogueWake;
  assign cmdStopAll   = reqStop;
endmodule // gwt_host_model

`default_nettype wire

// ### dv/general_and_wakeup_timers_tb.sv
// Self-checking bench for the general purpose and wake-up timers.
// Assumes the host model in front of the command inputs.
`timescale 1ns/1ns
`default_nettype none

module general_and_wakeup_timers_tb;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  gwt_pkg::gwt_mode_t opMode = gwt_pkg::GWT_MODE_READY;
  logic cTick = 1'b0, rTick = 1'b0, sel = 1'b0, sof = 1'b0, eof = 1'b0;
  logic pf = 1'b0, clr = 1'b0, rG = 1'b0, rW = 1'b0, rS = 1'b0, rgW = 1'b0;
  logic [15:0] genTo = 16'h0003, wakeTo = 16'h0002;
  logic cG, cW, cS, genRun, genExp, wakeRun, rcEn, tEn, wFlag, irq;
  int n_errors = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  gwt_host_model gwt_host_model_i (.reqGen(rG), .reqWake(rW), .reqStop(rS), .rogueWake(rgW),
    .opMode(opMode), .cmdStartGen(cG), .cmdStartWake(cW), .cmdStopAll(cS));
  gwt_timers gwt_timers_i (.clk(clk), .rst_n(rst_n), .opMode(opMode), .carrierTick(cTick),
    .rcTick(rTick), .genTrigSel(sel), .genTimeout(genTo), .wakeTimeout(wakeTo),
    .rxSofSeen(sof), .rxEofSeen(eof), .cmdStartGen(cG), .cmdStartWake(cW), .cmdStopAll(cS),
    .peerFieldDetected(pf), .wakeFlagClear(clr), .genRunning(genRun), .genExpired(genExp),
    .wakeRunning(wakeRun), .rcOscEnable(rcEn), .tempEnable(tEn),
    .wake_timer_expired_flag(wFlag), .irqReq(irq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task cyc; @(posedge clk); #1; endtask
  task chk(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %b seen %b", n, e, g);
      n_errors++;
    end
  endtask
  // An idle cycle before each tick keeps every tick a single-cycle pulse
  task tk(input bit rc, input int n);
    repeat (n) begin
      cyc;
      if (rc) rTick = 1'b1; else cTick = 1'b1;
      cyc;
      rTick = 1'b0;
      cTick = 1'b0;
    end
  endtask
  task send(input logic [2:0] r); {rS, rW, rG} = r; cyc; {rS, rW, rG} = 3'h0; endtask
  task rx(input bit e); if (e) eof = 1'b1; else sof = 1'b1; cyc; eof = 1'b0; sof = 1'b0; endtask
  task clear; clr = 1'b1; cyc; clr = 1'b0; cyc; endtask

  task gen_cmd;
    send(3'h1);
    chk("genRun", 1'b1, genRun);
    tk(0, 2);
    chk("genRun", 1'b1, genRun);
    tk(0, 1);
    chk("genExp", 1'b1, genExp);
    chk("genRun", 1'b0, genRun);
    cyc;
    chk("genExp", 1'b0, genExp);
    tk(0, 3);
    chk("genRun", 1'b0, genRun);
  endtask
  task gen_restart;
    send(3'h1);
    tk(0, 2);
    send(3'h1);
    tk(0, 2);
    chk("genRun", 1'b1, genRun);
    tk(0, 1);
    chk("genExp", 1'b1, genExp);
  endtask
  task gen_trig;
    sel = gwt_pkg::GEN_TRIG_RX_START;
    rx(1);
    chk("genRun", 1'b0, genRun);
    rx(0);
    chk("genRun", 1'b1, genRun);
    send(3'h4);
    sel = gwt_pkg::GEN_TRIG_RX_END;
    rx(0);
    chk("genRun", 1'b0, genRun);
    rx(1);
    chk("genRun", 1'b1, genRun);
    send(3'h4);
  endtask
  task wake_run;
    send(3'h2);
    chk("rcEn", 1'b1, rcEn);
    tk(1, 1);
    chk("wakeRun", 1'b1, wakeRun);
    tk(1, 1);
    chk("wakeRun", 1'b0, wakeRun);
    chk("rcEn", 1'b0, rcEn);
    chk("wFlag", 1'b1, wFlag);
    chk("irq", 1'b1, irq);
    clear;
    chk("irq", 1'b0, irq);
  endtask
  // Refusal in wake-up mode, ignored second start, and set winning over clear
  task wake_edge;
    opMode = gwt_pkg::GWT_MODE_WAKEUP;
    send(3'h2);
    chk("wakeRun", 1'b0, wakeRun);
    rgW = 1'b1;
    cyc;
    rgW = 1'b0;
    chk("wakeRun", 1'b0, wakeRun);
    opMode = gwt_pkg::GWT_MODE_READY;
    send(3'h2);
    tk(1, 1);
    send(3'h2);
    cyc;
    rTick = 1'b1;
    clr = 1'b1;
    cyc;
    rTick = 1'b0;
    clr = 1'b0;
    chk("wakeRun", 1'b0, wakeRun);
    chk("wFlag", 1'b1, wFlag);
    clear;
  endtask
  // The general purpose timer started before power-down must freeze there
  task pwr_dn;
    send(3'h1);
    opMode = gwt_pkg::GWT_MODE_PWRDN;
    tk(0, 3);
    chk("genRun", 1'b1, genRun);
    send(3'h4);
    send(3'h1);
    chk("genRun", 1'b0, genRun);
    send(3'h2);
    tk(1, 2);
    chk("wFlag", 1'b1, wFlag);
    clear;
    opMode = gwt_pkg::GWT_MODE_READY;
  endtask
  task stop_all;
    send(3'h3);
    chk("wakeRun", 1'b1, wakeRun);
    send(3'h4);
    chk("genRun", 1'b0, genRun);
    chk("wakeRun", 1'b0, wakeRun);
    tk(1, 2);
    chk("wFlag", 1'b0, wFlag);
  endtask
  task lpbr;
    opMode = gwt_pkg::GWT_MODE_LPBR;
    pf = 1'b1;
    cyc;
    pf = 1'b0;
    cyc;
    chk("tEn", 1'b1, tEn);
    tk(1, 2);
    chk("tEn", 1'b0, tEn);
    chk("wFlag", 1'b1, wFlag);
    clear;
    opMode = gwt_pkg::GWT_MODE_READY;
  endtask

  task end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc;
    gen_cmd;
    gen_restart;
    gen_trig;
    wake_run;
    wake_edge;
    pwr_dn;
    stop_all;
    lpbr;
    end_of_test;
  end
endmodule // general_and_wakeup_timers_tb

`default_nettype wire
